// [hub_link_pkg.sv]
`default_nettype none

package hub_link_pkg;

  // ----------------------------------------------------------------
  // slave addresses picked by the strap level
  // ----------------------------------------------------------------
  localparam logic [6:0] SLAVE_ADDR_HIGH = 7'h29;
  localparam logic [6:0] SLAVE_ADDR_LOW  = 7'h28;

  // ----------------------------------------------------------------
  // byte framing on the serial link
  // ----------------------------------------------------------------
  localparam int         DATA_W        = 8;
  localparam int         REG_ADDR_W    = 8;
  localparam int         WR_WORD_W     = REG_ADDR_W + DATA_W;
  localparam int         RX_SHIFT_W    = DATA_W + 1;
  localparam int         BIT_PTR_W     = 4;
  localparam int         PIN_SYNC_W    = 3;
  localparam int         PIN_SCL       = 0;
  localparam int         PIN_SDA       = 1;
  localparam int         PIN_STRAP     = 2;
  localparam logic [3:0] LAST_DATA_IDX = 4'h7;
  localparam logic [3:0] ACK_SLOT_IDX  = 4'h8;
  localparam logic [3:0] BIT_CNT_RESET = 4'h0;
  localparam logic [7:0] PTR_RESET     = 8'h00;
  localparam logic [7:0] PTR_STEP      = 8'h01;
  localparam logic [3:0] GRAY_STEP     = 4'h1;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int         CLK_PERIOD_PS  = 20000;
  localparam int         STRAP_HOLD_PS  = 10000;
  localparam int         STRAP_HOLD_RAW = (STRAP_HOLD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int         STRAP_HOLD_CYC = (STRAP_HOLD_RAW < 1) ? 1 : STRAP_HOLD_RAW;
  localparam logic [3:0] STRAP_HOLD_CNT = 4'(STRAP_HOLD_CYC);
  localparam int         HS_BIT_RATE_BPS = 3400000;

  // ----------------------------------------------------------------
  // protocol engine states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_REG,
    ST_WDATA,
    ST_RDATA,
    ST_IGNORE
  } link_state_e;

endpackage

`default_nettype wire

// [pair_buffer.sv]
`timescale 1ns/1ps
`default_nettype none

module pair_buffer #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic             clock_in,
  input  wire logic             srst_in,
  // filling side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // draining side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);

  localparam int IDX_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
  localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(DEPTH - 1);

  // ----------------------------------------------------------------
  // storage and pointers
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [IDX_W-1:0] wr_idx_r;
  logic [IDX_W-1:0] rd_idx_r;
  logic [CNT_W-1:0] count_r;
  wire              push_w = in_valid_in & in_ready_out;
  wire              pop_w  = out_valid_out & out_ready_in;

  assign in_ready_out  = (count_r != CNT_FULL);
  assign out_valid_out = (count_r != '0);
  assign out_data_out  = mem_r[rd_idx_r];

  always_ff @(posedge clock_in)
  begin
    if (push_w)
    begin
      mem_r[wr_idx_r] <= in_data_in;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      wr_idx_r <= '0;
      rd_idx_r <= '0;
      count_r  <= '0;
    end
    else
    begin
      if (push_w)
      begin
        wr_idx_r <= (wr_idx_r == IDX_LAST) ? '0 : IDX_W'(wr_idx_r + 1'b1);
      end
      if (pop_w)
      begin
        rd_idx_r <= (rd_idx_r == IDX_LAST) ? '0 : IDX_W'(rd_idx_r + 1'b1);
      end
      count_r <= CNT_W'(count_r + CNT_W'(push_w) - CNT_W'(pop_w));
    end
  end

endmodule

`default_nettype wire

// [host_i2c_slave_port.sv]
// Overview of operation
// - the port never starts a transfer and only reacts to traffic begun by the host.
// - the data line stays released until a matching slave address has been received.
// - a high latched strap selects address 0x29 and a low one selects 0x28.
// - once the address is latched the strap pin works as a general purpose I/O.
// - addresses and data move as eight-bit bytes, each with an acknowledge, clocked by the host.
// - single and multi byte register reads and writes are all supported.
// - only the host drives the clock line, while either side may drive the data line.
// - reads are write-address, register byte, repeated start, read-address, data, host NACK, stop.
// - the register address is one full byte sent most significant bit first.
// - transfers up to 3.4 Mbit/s high-speed mode are supported.
// - both bus lines are driven only as open-drain and rely on external pull-ups.
// - one interrupt output to the host sits beside the serial bus.
`timescale 1ns/1ps
`default_nettype none

module host_i2c_slave_port (
  // system clock and reset
  input  wire logic        clock_in,
  input  wire logic        srst_in,
  // serial bus, clock line
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe_n_out,
  // serial bus, data line
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n_out,
  // address strap and spare I/O pin
  input  wire logic        addr_strap_io_pin_in,
  output logic             addr_strap_io_pin_out,
  output logic             addr_strap_io_pin_oe_n_out,
  // spare I/O use by the application
  input  wire logic        gpio_level_in,
  input  wire logic        gpio_drive_in,
  output logic             gpio_level_out,
  output logic             strap_done_out,
  output logic             addr_sel_out,
  // host interrupt
  input  wire logic        irq_in,
  output logic             int_out,
  // register writes toward the register file
  output logic             wr_valid_out,
  input  wire logic        wr_ready_in,
  output logic [7:0]       wr_addr_out,
  output logic [7:0]       wr_data_out,
  // register reads from the register file
  output logic [7:0]       rd_addr_out,
  input  wire logic [7:0]  rd_data_in,
  output logic             rd_strobe_out,
  // status
  output logic             busy_out
);

  // ----------------------------------------------------------------
  // link domain: bit capture on the host clock
  // ----------------------------------------------------------------
  // shift and count only; framing is decided on the system clock, so
  // nothing here needs to see start or stop conditions
  logic                                      lrst_s1_r;
  logic                                      lrst_s2_r;
  logic [hub_link_pkg::BIT_PTR_W-1:0]        bit_bin_r;
  logic [hub_link_pkg::BIT_PTR_W-1:0]        bit_gray_r;
  logic [hub_link_pkg::RX_SHIFT_W-1:0]       rx_shift_r;
  logic [hub_link_pkg::BIT_PTR_W-1:0]        bit_bin_nxt;
  logic [hub_link_pkg::BIT_PTR_W-1:0]        bit_gray_nxt;

  assign bit_bin_nxt  = bit_bin_r + hub_link_pkg::GRAY_STEP;
  assign bit_gray_nxt = bit_bin_nxt ^ (bit_bin_nxt >> 1);

  always_ff @(posedge scl_in)
  begin
    lrst_s1_r <= srst_in;
    lrst_s2_r <= lrst_s1_r;
  end

  always_ff @(posedge scl_in)
  begin
    if (lrst_s2_r)
    begin
      bit_bin_r  <= '0;
      bit_gray_r <= '0;
      rx_shift_r <= '0;
    end
    else
    begin
      bit_bin_r  <= bit_bin_nxt;
      bit_gray_r <= bit_gray_nxt;
      rx_shift_r <= {rx_shift_r[hub_link_pkg::RX_SHIFT_W-2:0], sda_in};
    end
  end

  // ----------------------------------------------------------------
  // crossing into the system domain
  // ----------------------------------------------------------------
  // a gray pointer step marks a new bit; rx_shift_r then stays put for
  // a whole bit period, far longer than the two-flop latency
  logic [hub_link_pkg::BIT_PTR_W-1:0]  gray_s1_r;
  logic [hub_link_pkg::BIT_PTR_W-1:0]  gray_s2_r;
  logic [hub_link_pkg::BIT_PTR_W-1:0]  gray_seen_r;
  logic [hub_link_pkg::PIN_SYNC_W-1:0] pin_s1_r;
  logic [hub_link_pkg::PIN_SYNC_W-1:0] pin_s2_r;
  logic [hub_link_pkg::PIN_SYNC_W-1:0] pin_prev_r;
  wire  [hub_link_pkg::PIN_SYNC_W-1:0] pin_raw_w;

  assign pin_raw_w = {addr_strap_io_pin_in, sda_in, scl_in};

  always_ff @(posedge clock_in)
  begin
    gray_s1_r  <= bit_gray_r;
    gray_s2_r  <= gray_s1_r;
    pin_s1_r   <= pin_raw_w;
    pin_s2_r   <= pin_s1_r;
    pin_prev_r <= pin_s2_r;
  end

  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      gray_seen_r <= '0;
    end
    else
    begin
      gray_seen_r <= gray_s2_r;
    end
  end

  // ----------------------------------------------------------------
  // bus condition decode
  // ----------------------------------------------------------------
  wire scl_lvl_w  = pin_s2_r[hub_link_pkg::PIN_SCL];
  wire sda_lvl_w  = pin_s2_r[hub_link_pkg::PIN_SDA];
  wire scl_prev_w = pin_prev_r[hub_link_pkg::PIN_SCL];
  wire sda_prev_w = pin_prev_r[hub_link_pkg::PIN_SDA];
  wire start_evt_w = scl_lvl_w & scl_prev_w & sda_prev_w & ~sda_lvl_w;
  wire stop_evt_w  = scl_lvl_w & scl_prev_w & ~sda_prev_w & sda_lvl_w;
  wire scl_fall_w  = scl_prev_w & ~scl_lvl_w;
  wire bit_evt_w   = (gray_s2_r != gray_seen_r);

  // ----------------------------------------------------------------
  // address strap
  // ----------------------------------------------------------------
  // the pin is read only after the hold window, then handed to the
  // application as plain I/O
  logic       strap_done_r;
  logic       addr_sel_r;
  logic [3:0] strap_cnt_r;
  logic       gpio_oe_n_r;
  logic       gpio_drv_r;
  logic       gpio_lvl_r;
  logic       int_r;

  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      strap_done_r <= 1'b0;
      addr_sel_r   <= 1'b0;
      strap_cnt_r  <= hub_link_pkg::BIT_CNT_RESET;
    end
    else if (!strap_done_r)
    begin
      strap_cnt_r <= strap_cnt_r + hub_link_pkg::GRAY_STEP;
      if (strap_cnt_r == hub_link_pkg::STRAP_HOLD_CNT)
      begin
        strap_done_r <= 1'b1;
        addr_sel_r   <= pin_s2_r[hub_link_pkg::PIN_STRAP];
      end
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      gpio_oe_n_r <= 1'b1;
      gpio_drv_r  <= 1'b0;
      gpio_lvl_r  <= 1'b0;
      int_r       <= 1'b0;
    end
    else
    begin
      gpio_oe_n_r <= ~(strap_done_r & gpio_drive_in);
      gpio_drv_r  <= gpio_level_in;
      gpio_lvl_r  <= pin_s2_r[hub_link_pkg::PIN_STRAP];
      int_r       <= irq_in;
    end
  end

  wire [6:0] own_addr_w = addr_sel_r ? hub_link_pkg::SLAVE_ADDR_HIGH
                                     : hub_link_pkg::SLAVE_ADDR_LOW;

  // ----------------------------------------------------------------
  // protocol engine
  // ----------------------------------------------------------------
  hub_link_pkg::link_state_e state_r;
  hub_link_pkg::link_state_e state_nxt;
  logic [3:0] bit_cnt_r;
  logic [3:0] bit_cnt_nxt;
  logic       ack_r;
  logic       ack_nxt;
  logic       drive_low_r;
  logic       drive_low_nxt;
  logic [7:0] ptr_r;
  logic [7:0] ptr_nxt;
  logic [7:0] tx_r;
  logic [7:0] tx_nxt;
  logic       rd_first_r;
  logic       rd_first_nxt;
  logic       rd_take;
  logic       push;
  logic       buf_ready;

  wire [7:0] rx_byte_w  = rx_shift_r[hub_link_pkg::DATA_W-1:0];
  wire       host_nak_w = rx_shift_r[0];
  wire       addr_hit_w = (rx_byte_w[7:1] == own_addr_w);
  wire [2:0] tx_idx_w   = 3'(hub_link_pkg::LAST_DATA_IDX - bit_cnt_r);
  wire       in_byte_w  = (bit_cnt_r == hub_link_pkg::LAST_DATA_IDX);
  wire       in_ack_w   = (bit_cnt_r == hub_link_pkg::ACK_SLOT_IDX);
  wire [7:0] ptr_inc_w  = 8'(ptr_r + hub_link_pkg::PTR_STEP);

  always_comb
  begin
    state_nxt     = state_r;
    bit_cnt_nxt   = bit_cnt_r;
    ack_nxt       = ack_r;
    drive_low_nxt = drive_low_r;
    ptr_nxt       = ptr_r;
    tx_nxt        = tx_r;
    rd_first_nxt  = rd_first_r;
    rd_take       = 1'b0;
    push          = 1'b0;
    if (!strap_done_r)
    begin
      state_nxt = hub_link_pkg::ST_IDLE;
    end
    else if (start_evt_w)
    begin
      // also a repeated start: drop whatever was in progress
      state_nxt     = hub_link_pkg::ST_ADDR;
      bit_cnt_nxt   = hub_link_pkg::BIT_CNT_RESET;
      ack_nxt       = 1'b0;
      drive_low_nxt = 1'b0;
    end
    else if (stop_evt_w)
    begin
      state_nxt     = hub_link_pkg::ST_IDLE;
      ack_nxt       = 1'b0;
      drive_low_nxt = 1'b0;
    end
    else if (bit_evt_w && state_r != hub_link_pkg::ST_IDLE)
    begin
      if (in_byte_w)
      begin
        bit_cnt_nxt = hub_link_pkg::ACK_SLOT_IDX;
        ack_nxt     = 1'b0;
        case (state_r)
          hub_link_pkg::ST_ADDR:
          begin
            if (addr_hit_w)
            begin
              ack_nxt      = 1'b1;
              rd_first_nxt = rx_byte_w[0];
              state_nxt    = rx_byte_w[0] ? hub_link_pkg::ST_RDATA
                                          : hub_link_pkg::ST_REG;
            end
            else
            begin
              state_nxt = hub_link_pkg::ST_IGNORE;
            end
          end
          hub_link_pkg::ST_REG:
          begin
            ptr_nxt   = rx_byte_w;
            ack_nxt   = 1'b1;
            state_nxt = hub_link_pkg::ST_WDATA;
          end
          hub_link_pkg::ST_WDATA:
          begin
            // a full buffer turns into a NACK so no byte is lost silently
            if (buf_ready)
            begin
              push    = 1'b1;
              ack_nxt = 1'b1;
              ptr_nxt = ptr_inc_w;
            end
          end
          default:
          begin
            ack_nxt = 1'b0;
          end
        endcase
      end
      else if (in_ack_w)
      begin
        bit_cnt_nxt = hub_link_pkg::BIT_CNT_RESET;
        if (state_r == hub_link_pkg::ST_RDATA)
        begin
          if (rd_first_r || !host_nak_w)
          begin
            tx_nxt       = rd_data_in;
            ptr_nxt      = ptr_inc_w;
            rd_first_nxt = 1'b0;
            rd_take      = 1'b1;
          end
          else
          begin
            state_nxt = hub_link_pkg::ST_IGNORE;
          end
        end
      end
      else
      begin
        bit_cnt_nxt = bit_cnt_r + hub_link_pkg::GRAY_STEP;
      end
    end
    else if (scl_fall_w)
    begin
      // change the data line only while the clock is low
      if (in_ack_w)
      begin
        drive_low_nxt = ack_r;
      end
      else if (state_r == hub_link_pkg::ST_RDATA)
      begin
        drive_low_nxt = ~tx_r[tx_idx_w];
      end
      else
      begin
        drive_low_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      state_r       <= hub_link_pkg::ST_IDLE;
      bit_cnt_r     <= hub_link_pkg::BIT_CNT_RESET;
      ack_r         <= 1'b0;
      drive_low_r   <= 1'b0;
      ptr_r         <= hub_link_pkg::PTR_RESET;
      tx_r          <= hub_link_pkg::PTR_RESET;
      rd_first_r    <= 1'b0;
      rd_strobe_out <= 1'b0;
    end
    else
    begin
      state_r       <= state_nxt;
      bit_cnt_r     <= bit_cnt_nxt;
      ack_r         <= ack_nxt;
      drive_low_r   <= drive_low_nxt;
      ptr_r         <= ptr_nxt;
      tx_r          <= tx_nxt;
      rd_first_r    <= rd_first_nxt;
      rd_strobe_out <= rd_take;
    end
  end

  // ----------------------------------------------------------------
  // write buffer toward the register file
  // ----------------------------------------------------------------
  logic [hub_link_pkg::WR_WORD_W-1:0] buf_out;

  pair_buffer #(
    .WIDTH (hub_link_pkg::WR_WORD_W),
    .DEPTH (2)
  ) u_wr_buffer (
    .clock_in      (clock_in),
    .srst_in       (srst_in),
    .in_valid_in   (push),
    .in_ready_out  (buf_ready),
    .in_data_in    ({ptr_r, rx_byte_w}),
    .out_valid_out (wr_valid_out),
    .out_ready_in  (wr_ready_in),
    .out_data_out  (buf_out)
  );

  assign wr_addr_out = buf_out[hub_link_pkg::WR_WORD_W-1:hub_link_pkg::DATA_W];
  assign wr_data_out = buf_out[hub_link_pkg::DATA_W-1:0];

  // ----------------------------------------------------------------
  // pins and outputs
  // ----------------------------------------------------------------
  // bus lines open-drain only: their driven level is always low; the strap pin drives either level
  assign sda_out      = 1'b0;
  assign sda_oe_n_out = ~drive_low_r;
  assign scl_out      = 1'b0;
  assign scl_oe_n_out = 1'b1;
  assign addr_strap_io_pin_out      = gpio_drv_r;
  assign addr_strap_io_pin_oe_n_out = gpio_oe_n_r;
  assign gpio_level_out = gpio_lvl_r;
  assign strap_done_out = strap_done_r;
  assign addr_sel_out   = addr_sel_r;
  assign int_out        = int_r;
  assign rd_addr_out    = ptr_r;
  // hs rate works because decisions land within four system cycles
  // of a clock edge, inside the shortest low phase
  assign busy_out = (state_r != hub_link_pkg::ST_IDLE);

endmodule

`default_nettype wire

// [host_i2c_slave_port_assertions.sv]
`timescale 1ns/1ps
`default_nettype none

module host_i2c_slave_port_assertions (
  // clock and reset
  input  wire logic       clock_in,
  input  wire logic       srst_in,
  // bus lines
  input  wire logic       scl_out,
  input  wire logic       scl_oe_n_out,
  input  wire logic       sda_out,
  input  wire logic       sda_oe_n_out,
  // strap pin and spare I/O
  input  wire logic       addr_strap_io_pin_in,
  input  wire logic       addr_strap_io_pin_out,
  input  wire logic       addr_strap_io_pin_oe_n_out,
  input  wire logic       gpio_level_in,
  input  wire logic       gpio_drive_in,
  input  wire logic       strap_done_out,
  input  wire logic       addr_sel_out,
  // interrupt, register ports, status
  input  wire logic       irq_in,
  input  wire logic       int_out,
  input  wire logic       wr_valid_out,
  input  wire logic       wr_ready_in,
  input  wire logic [7:0] wr_addr_out,
  input  wire logic [7:0] wr_data_out,
  input  wire logic       rd_strobe_out,
  input  wire logic       busy_out
);
  default clocking @(posedge clock_in);
  endclocking
  default disable iff (srst_in);

  // ----------------------------------------------------------------
  // bus lines
  // ----------------------------------------------------------------
  scl_released_a: assert property (scl_oe_n_out)
    else $error("clock line driven by slave");
  open_drain_a: assert property (!sda_out && !scl_out)
    else $error("bus line driven high");
  idle_passive_a: assert property (!busy_out && !$past(busy_out) |-> sda_oe_n_out)
    else $error("data line driven outside a frame");

  // ----------------------------------------------------------------
  // strap, spare pin, interrupt
  // ----------------------------------------------------------------
  strap_addr_a: assert property ($rose(strap_done_out) |-> addr_sel_out == $past(addr_strap_io_pin_in, 2))
    else $error("latched strap level wrong");
  strap_time_a: assert property ($fell(srst_in) |-> ##[0:3] strap_done_out)
    else $error("strap not latched in time");
  pin_gate_a: assert property (!addr_strap_io_pin_oe_n_out |-> strap_done_out)
    else $error("strap pin driven before latch");
  pin_follow_a: assert property (strap_done_out && gpio_drive_in |=> !addr_strap_io_pin_oe_n_out && addr_strap_io_pin_out == $past(gpio_level_in))
    else $error("spare pin not driven as asked");
  int_copy_a: assert property (1'b1 |=> int_out == $past(irq_in))
    else $error("interrupt output not one cycle behind");

  // ----------------------------------------------------------------
  // register ports
  // ----------------------------------------------------------------
  wr_hold_a: assert property (wr_valid_out && !wr_ready_in |=> wr_valid_out && $stable(wr_addr_out) && $stable(wr_data_out))
    else $error("write word lost while stalled");
  rd_pulse_a: assert property (rd_strobe_out |-> busy_out ##1 !rd_strobe_out)
    else $error("read strobe not a single pulse in frame");

  cover property (wr_valid_out && wr_ready_in);
  cover property (rd_strobe_out);
  cover property (!sda_oe_n_out);
  cover property (!addr_strap_io_pin_oe_n_out);
endmodule

bind host_i2c_slave_port host_i2c_slave_port_assertions host_i2c_slave_port_assertions_i (
  .clock_in(clock_in), .srst_in(srst_in), .scl_out(scl_out), .scl_oe_n_out(scl_oe_n_out),
  .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out), .addr_strap_io_pin_in(addr_strap_io_pin_in),
  .addr_strap_io_pin_out(addr_strap_io_pin_out),
  .addr_strap_io_pin_oe_n_out(addr_strap_io_pin_oe_n_out), .gpio_level_in(gpio_level_in),
  .gpio_drive_in(gpio_drive_in), .strap_done_out(strap_done_out), .addr_sel_out(addr_sel_out),
  .irq_in(irq_in), .int_out(int_out), .wr_valid_out(wr_valid_out), .wr_ready_in(wr_ready_in),
  .wr_addr_out(wr_addr_out), .wr_data_out(wr_data_out), .rd_strobe_out(rd_strobe_out),
  .busy_out(busy_out)
);

`default_nettype wire

// [i2c_host_model.sv]
`timescale 1ns/1ps
`default_nettype none

module i2c_host_model (
  // link clock
  input  wire logic link_clk_in,
  // bus lines
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_low_out
);
  initial
  begin
    scl_out = 1'h1;
    sda_low_out = 1'h0;
  end

  // ----------------------------------------------------------------
  // bit timing: two link ticks a phase keeps each phase over 100 ns
  // ----------------------------------------------------------------
  task automatic half();
    repeat (2) @(posedge link_clk_in);
  endtask

  // clocks with data released, only to clear link regs in reset and let their reset end
  task automatic idle_clocks(input int n);
    repeat (n)
    begin
      scl_out <= 1'h0;
      half();
      scl_out <= 1'h1;
      half();
    end
  endtask

  task automatic start();
    half();
    sda_low_out <= 1'h0;
    half();
    scl_out <= 1'h1;
    half();
    sda_low_out <= 1'h1;
    half();
    scl_out <= 1'h0;
  endtask

  task automatic stop();
    sda_low_out <= 1'h1;
    half();
    scl_out <= 1'h1;
    half();
    sda_low_out <= 1'h0;
    half();
  endtask

  // data changes only while the clock is low; sampled late in high
  task automatic bit_slot(input logic b, output logic s);
    sda_low_out <= !b;
    half();
    scl_out <= 1'h1;
    half();
    s = sda_in;
    scl_out <= 1'h0;
  endtask

  task automatic xfer(input logic [7:0] tx, input logic ack_tx, output logic [7:0] rx,
                      output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_slot(tx[i], s);
      rx[i] = s;
    end
    bit_slot(ack_tx, ack);
  endtask
endmodule

`default_nettype wire

// [testbench.sv]
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic       clock_in = 1'h0;
  logic       link_clk;
  logic       srst_in, strap_lvl, gpio_level_in, gpio_drive_in, irq_in, wr_ready_in;
  logic       scl_m, sda_low_m, scl_out, scl_oe_n_out, sda_out, sda_oe_n_out;
  logic       pin_out, pin_oe_n, gpio_level_out, strap_done_out, addr_sel_out, int_out;
  logic       wr_valid_out, rd_strobe_out, busy_out;
  logic [7:0] wr_addr_out, wr_data_out, rd_addr_out;
  wire  logic scl_w, sda_w, pin_w;
  wire  logic [7:0] rd_data;
  int         fails = 0;
  int         checked = 0;

  always #10 clock_in = ~clock_in;
  initial
  begin
    link_clk = 1'h0;
    #7;
    forever #32 link_clk = ~link_clk;
  end

  // open-drain lines with pull-ups; strap pin belongs to the bench until driven
  assign scl_w = scl_m & (scl_oe_n_out | scl_out);
  assign sda_w = !sda_low_m & (sda_oe_n_out | sda_out);
  assign pin_w = pin_oe_n ? strap_lvl : pin_out;
  assign rd_data = rd_addr_out ^ 8'h5A;

  i2c_host_model i2c_host_model_i (.link_clk_in(link_clk), .sda_in(sda_w), .scl_out(scl_m),
    .sda_low_out(sda_low_m));

  host_i2c_slave_port host_i2c_slave_port_i (.clock_in(clock_in), .srst_in(srst_in),
    .scl_in(scl_w), .scl_out(scl_out), .scl_oe_n_out(scl_oe_n_out), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out), .addr_strap_io_pin_in(pin_w),
    .addr_strap_io_pin_out(pin_out), .addr_strap_io_pin_oe_n_out(pin_oe_n),
    .gpio_level_in(gpio_level_in), .gpio_drive_in(gpio_drive_in),
    .gpio_level_out(gpio_level_out), .strap_done_out(strap_done_out),
    .addr_sel_out(addr_sel_out), .irq_in(irq_in), .int_out(int_out),
    .wr_valid_out(wr_valid_out), .wr_ready_in(wr_ready_in), .wr_addr_out(wr_addr_out),
    .wr_data_out(wr_data_out), .rd_addr_out(rd_addr_out), .rd_data_in(rd_data),
    .rd_strobe_out(rd_strobe_out), .busy_out(busy_out));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("mismatches %0d, comparisons %0d", fails, checked);
    if (fails == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // line level in the ninth slot: 0 is an acknowledge
  task automatic send(input logic [7:0] b, input logic exp_line);
    logic [7:0] rx;
    logic       ack;
    i2c_host_model_i.xfer(b, 1'h1, rx, ack);
    check(8'(ack), 8'(exp_line));
  endtask

  task automatic pop(input logic [7:0] ea, input logic [7:0] ed);
    int n;
    n = 0;
    while (wr_valid_out !== 1'h1 && n < 40)
    begin
      @(negedge clock_in);
      n++;
    end
    if (wr_valid_out !== 1'h1)
    begin
      fails++;
      stop_test();
    end
    check(wr_addr_out, ea);
    check(wr_data_out, ed);
    @(posedge clock_in);
    wr_ready_in <= 1'h1;
    @(posedge clock_in);
    wr_ready_in <= 1'h0;
    @(negedge clock_in);
  endtask

  // strap held through the latch, then turned round: address must not follow
  task automatic do_reset(input logic lvl);
    @(posedge clock_in);
    srst_in <= 1'h1;
    strap_lvl <= lvl;
    i2c_host_model_i.idle_clocks(3);
    repeat (3) @(posedge clock_in);
    srst_in <= 1'h0;
    repeat (5) @(posedge clock_in);
    strap_lvl <= !lvl;
    @(negedge clock_in);
    check(8'(strap_done_out), 8'h01);
    check(8'(addr_sel_out), 8'(lvl));
    i2c_host_model_i.idle_clocks(2);  // link reset ends two edges late
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic s_gpio();
    @(posedge clock_in);
    gpio_drive_in <= 1'h1;
    gpio_level_in <= !strap_lvl;
    repeat (5) @(negedge clock_in);
    check(8'(pin_oe_n), 8'h00);
    check(8'(gpio_level_out), 8'(!strap_lvl));
    @(posedge clock_in);
    gpio_drive_in <= 1'h0;
    irq_in <= 1'h1;
    @(posedge clock_in);
    @(negedge clock_in);
    check(8'(int_out), 8'h01);
    irq_in <= 1'h0;
  endtask

  // burst with the consumer stalled: two words fill the buffer, third refused
  task automatic s_write(input logic [6:0] a);
    i2c_host_model_i.start();
    send({a, 1'h0}, 1'h0);
    send(8'h10, 1'h0);
    send(8'hAB, 1'h0);
    send(8'hCD, 1'h0);
    send(8'hEF, 1'h1);
    i2c_host_model_i.stop();
    pop(8'h10, 8'hAB);
    pop(8'h11, 8'hCD);
    repeat (3) @(negedge clock_in);
    check(8'(wr_valid_out), 8'h00);
  endtask

  task automatic s_wrong(input logic [6:0] a);
    i2c_host_model_i.start();
    send({a, 1'h0}, 1'h1);
    send(8'h00, 1'h1);
    send(8'h00, 1'h1);
    i2c_host_model_i.stop();
    check(8'(wr_valid_out), 8'h00);
  endtask

  task automatic s_read(input logic [6:0] a);
    logic [7:0] rx;
    logic       ack;
    i2c_host_model_i.start();
    send({a, 1'h0}, 1'h0);
    send(8'h20, 1'h0);
    i2c_host_model_i.start();
    send({a, 1'h1}, 1'h0);
    i2c_host_model_i.xfer(8'hFF, 1'h0, rx, ack);
    check(rx, 8'h20 ^ 8'h5A);
    i2c_host_model_i.xfer(8'hFF, 1'h1, rx, ack);
    check(rx, 8'h21 ^ 8'h5A);
    i2c_host_model_i.stop();
    check(rd_addr_out, 8'h22);
  endtask

  initial
  begin
    srst_in = 1'h1;
    strap_lvl = 1'h0;
    gpio_level_in = 1'h0;
    gpio_drive_in = 1'h0;
    irq_in = 1'h0;
    wr_ready_in = 1'h0;
    do_reset(1'h0);
    s_gpio();
    s_write(hub_link_pkg::SLAVE_ADDR_LOW);
    s_wrong(hub_link_pkg::SLAVE_ADDR_HIGH);
    s_read(hub_link_pkg::SLAVE_ADDR_LOW);
    do_reset(1'h1);
    s_write(hub_link_pkg::SLAVE_ADDR_HIGH);
    s_wrong(hub_link_pkg::SLAVE_ADDR_LOW);
    stop_test();
  end
endmodule

`default_nettype wire
